// ---- src/bcc_pkg.sv ----
// Package: register map, field positions, reset values and carriers for converter one control
package bcc_pkg;

  // ==========================================================================
  // Register offsets and reset values
  localparam logic [7:0] BCC_ENABLE_SLEEP_ADDR     = 8'h44;
  localparam logic [7:0] BCC_RESET_DEBOUNCE_ADDR   = 8'h45;
  localparam logic [7:0] BCC_SOFTSTART_LP_ADDR     = 8'h46;
  localparam logic [7:0] BCC_ENABLE_SLEEP_RST      = 8'h42;
  localparam logic [7:0] BCC_RESET_DEBOUNCE_RST    = 8'h93;
  localparam logic [7:0] BCC_SOFTSTART_LP_RST      = 8'h21;

  // ==========================================================================
  // Field positions, first register
  localparam int BCC_DIRECT_ON_BIT      = 7;
  localparam int BCC_SEQ_SOURCE_BIT     = 6;
  localparam int BCC_LATCH_ON_BIT       = 5;
  localparam int BCC_SLEEP_OFF_BIT      = 4;
  localparam int BCC_DEEP_OFF_BIT       = 2;
  localparam int BCC_PEAK_LIMIT_BIT     = 1;
  // Second register
  localparam int BCC_MODE_BIT           = 7;
  localparam int BCC_RESET_LINK_BIT     = 6;
  localparam int BCC_QUALIFY_LSB        = 3;
  localparam int BCC_GOOD_LSB           = 0;
  // Third register
  localparam int BCC_TURN_ON_LSB        = 4;
  localparam int BCC_SOFT_START_BIT     = 3;
  localparam int BCC_LP_DISABLE_BIT     = 2;
  localparam int BCC_STANDBY_LSB        = 0;

  // ==========================================================================
  // Power states of the device as seen by this block
  typedef enum logic [2:0] {
    BCC_PWR_ACTIVE     = 3'b001,
    BCC_PWR_SLEEP      = 3'b010,
    BCC_PWR_DEEP_SLEEP = 3'b100
  } bcc_pwr_t;

  // Register write/read port carrier
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bcc_req_t;

  // Decoded configuration towards the converter
  typedef struct packed {
    logic       seq_source_select;
    logic       startup_mode;
    logic [2:0] qualify_debounce;
    logic [2:0] good_debounce;
    logic [3:0] turn_on_debounce;
    logic       soft_start_time;
    logic [1:0] standby_input_select;
  } bcc_seq_cfg_t;

endpackage : bcc_pkg

// ---- src/bcc_control.sv ----
// Module: configuration registers and on/off control of the first step-down converter
// What this block does
// - Direct-enable bit set: converter follows host write, bypassing sequencer; else sequencer.
// - Latch-on clear: converter drops with its sequencing input; set: stays on.
// - Sleep-off bit set turns converter off in Sleep; clear keeps it on.
// - Deep-sleep-off bit set turns converter off in Deep Sleep; clear keeps it.
// - Limit select: clear picks 3.8A peak limit, set picks 5.0A.
// - Reset-link set: converter off drives system reset low; clear: no effect.
// - Low-power-disable set forbids low-power mode; clear allows it.
// - Factory sequencing and debounce fields drive the startup sequencing configuration.
// - Two-bit standby field selects which inputs control voltage scaling.
// - Registers reset to 0x42, 0x93 and 0x21 at 0x44, 0x45, 0x46.
module bcc_control
  import bcc_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire bcc_req_t     reg_req,
  input  wire logic         seq_enable,
  input  wire logic         seq_input_on,
  input  wire bcc_pwr_t     pwr_state,
  output logic [7:0]        reg_rdata_ff,
  output logic              reg_rvalid_ff,
  output logic              conv_on_ff,
  output logic              peak_limit_select_ff,
  output logic              low_power_allow_ff,
  output logic              system_reset_out_n_ff,
  output bcc_seq_cfg_t      seq_cfg_ff
);

  // ==========================================================================
  // Helper functions
  // One-hot register select; shared by the write path and the read path
  function automatic logic [2:0] reg_select(input logic [7:0] addr);
    logic [2:0] sel;
    sel = 3'h0;
    unique case (addr)
      BCC_ENABLE_SLEEP_ADDR:   sel = 3'h1;
      BCC_RESET_DEBOUNCE_ADDR: sel = 3'h2;
      BCC_SOFTSTART_LP_ADDR:   sel = 3'h4;
      default:                 sel = 3'h0;
    endcase
    return sel;
  endfunction : reg_select

  // Next value of one register: a write replaces the whole byte, reserved bits included
  function automatic logic [7:0] write_merge(
    input logic       hit,
    input logic [7:0] cur,
    input logic [7:0] wdata
  );
    logic [7:0] res;
    res = cur;
    if (hit) begin
      res = wdata;
    end
    return res;
  endfunction : write_merge

  // Read data for a one-hot select; no select reads as zero
  function automatic logic [7:0] read_mux(
    input logic [2:0] sel,
    input logic [7:0] cfg_en,
    input logic [7:0] cfg_rst,
    input logic [7:0] cfg_ss
  );
    logic [7:0] res;
    res = 8'h00;
    unique case (sel)
      3'h1:    res = cfg_en;
      3'h2:    res = cfg_rst;
      3'h4:    res = cfg_ss;
      default: res = 8'h00;
    endcase
    return res;
  endfunction : read_mux

  // Power-state override: the sleep-off bits win over direct enable and the sequencer
  function automatic logic pwr_forces_off(
    input logic [7:0] cfg_en,
    input bcc_pwr_t   pwr
  );
    logic off;
    off = 1'b0;
    unique case (pwr)
      BCC_PWR_ACTIVE:     off = 1'b0;
      BCC_PWR_SLEEP:      off = cfg_en[BCC_SLEEP_OFF_BIT];
      BCC_PWR_DEEP_SLEEP: off = cfg_en[BCC_DEEP_OFF_BIT];
      default:            off = 1'b0;
    endcase
    return off;
  endfunction : pwr_forces_off

  // Sequencer path: with the latch-on bit set the converter rides through a drop of its input
  function automatic logic seq_gate(
    input logic enable,
    input logic input_on,
    input logic latch_on,
    input logic latched
  );
    logic on;
    on = 1'b0;
    if (enable) begin
      on = input_on || (latch_on && latched);
    end
    return on;
  endfunction : seq_gate

  // Reset output level: low only while the link is set and the converter is off
  function automatic logic reset_level(
    input logic link,
    input logic on
  );
    logic level;
    level = !(link && !on);
    return level;
  endfunction : reset_level

  // Factory fields are passed through untouched; their meaning lives in the sequencer
  function automatic bcc_seq_cfg_t seq_fields(
    input logic [7:0] cfg_en,
    input logic [7:0] cfg_rst,
    input logic [7:0] cfg_ss
  );
    bcc_seq_cfg_t f;
    f.seq_source_select    = cfg_en[BCC_SEQ_SOURCE_BIT];
    f.startup_mode         = cfg_rst[BCC_MODE_BIT];
    f.qualify_debounce     = cfg_rst[BCC_QUALIFY_LSB +: 3];
    f.good_debounce        = cfg_rst[BCC_GOOD_LSB +: 3];
    f.turn_on_debounce     = cfg_ss[BCC_TURN_ON_LSB +: 4];
    f.soft_start_time      = cfg_ss[BCC_SOFT_START_BIT];
    f.standby_input_select = cfg_ss[BCC_STANDBY_LSB +: 2];
    return f;
  endfunction : seq_fields

  // ==========================================================================
  // Write select
  logic [2:0] wr_sel;

  // Reserved and factory bits are stored as written; the host must write them back unchanged
  always_comb begin
    wr_sel = reg_req.wr_en ? reg_select(reg_req.addr) : 3'h0;
  end

  // Enable and sleep register
  logic [7:0] cfg_en_ff;
  logic [7:0] nxt_cfg_en;

  always_comb begin
    nxt_cfg_en = write_merge(wr_sel[0], cfg_en_ff, reg_req.wdata);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_en_ff <= BCC_ENABLE_SLEEP_RST;
    end else begin
      cfg_en_ff <= nxt_cfg_en;
    end
  end

  // Reset link and debounce register
  logic [7:0] cfg_rst_ff;
  logic [7:0] nxt_cfg_rst;

  always_comb begin
    nxt_cfg_rst = write_merge(wr_sel[1], cfg_rst_ff, reg_req.wdata);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_rst_ff <= BCC_RESET_DEBOUNCE_RST;
    end else begin
      cfg_rst_ff <= nxt_cfg_rst;
    end
  end

  // Soft-start and low-power register
  logic [7:0] cfg_ss_ff;
  logic [7:0] nxt_cfg_ss;

  always_comb begin
    nxt_cfg_ss = write_merge(wr_sel[2], cfg_ss_ff, reg_req.wdata);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_ss_ff <= BCC_SOFTSTART_LP_RST;
    end else begin
      cfg_ss_ff <= nxt_cfg_ss;
    end
  end

  // ==========================================================================
  // Read response
  logic [2:0] rd_sel;
  logic [7:0] nxt_rdata;
  logic       nxt_rvalid;

  // Unmapped addresses still answer, with zero data; a read in the same cycle as a
  // write to that register returns the old value
  always_comb begin
    rd_sel     = reg_req.rd_en ? reg_select(reg_req.addr) : 3'h0;
    nxt_rvalid = reg_req.rd_en;
    nxt_rdata  = read_mux(rd_sel, cfg_en_ff, cfg_rst_ff, cfg_ss_ff);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_ff  <= 8'h00;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rdata_ff  <= nxt_rdata;
      reg_rvalid_ff <= nxt_rvalid;
    end
  end

  // ==========================================================================
  // Sequencer latch
  // Remembers that the sequencing input was seen on; cleared only when the sequencer drops
  logic latched_on_ff;
  logic nxt_latched_on;

  always_comb begin
    nxt_latched_on = latched_on_ff;
    if (!seq_enable) begin
      nxt_latched_on = 1'b0;
    end else if (seq_input_on) begin
      nxt_latched_on = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      latched_on_ff <= 1'b0;
    end else begin
      latched_on_ff <= nxt_latched_on;
    end
  end

  // ==========================================================================
  // Converter enable
  // Built from next register values so a write reaches the pin at the edge it lands
  logic seq_on;
  logic nxt_on;

  always_comb begin
    seq_on = seq_gate(seq_enable, seq_input_on, nxt_cfg_en[BCC_LATCH_ON_BIT], latched_on_ff);
    if (nxt_cfg_en[BCC_DIRECT_ON_BIT]) begin
      nxt_on = 1'b1;
    end else begin
      nxt_on = seq_on;
    end
    if (pwr_forces_off(nxt_cfg_en, pwr_state)) begin
      nxt_on = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      conv_on_ff <= 1'b0;
    end else begin
      conv_on_ff <= nxt_on;
    end
  end

  // ==========================================================================
  // Peak current limit
  logic nxt_limit;

  always_comb begin
    nxt_limit = nxt_cfg_en[BCC_PEAK_LIMIT_BIT];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      peak_limit_select_ff <= BCC_ENABLE_SLEEP_RST[BCC_PEAK_LIMIT_BIT];
    end else begin
      peak_limit_select_ff <= nxt_limit;
    end
  end

  // ==========================================================================
  // Low-power permission
  logic nxt_lp_allow;

  always_comb begin
    nxt_lp_allow = !nxt_cfg_ss[BCC_LP_DISABLE_BIT];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_power_allow_ff <= !BCC_SOFTSTART_LP_RST[BCC_LP_DISABLE_BIT];
    end else begin
      low_power_allow_ff <= nxt_lp_allow;
    end
  end

  // ==========================================================================
  // System reset link
  // Level, not pulse: reset stays low for as long as the converter is off and linked
  logic nxt_reset_n;

  always_comb begin
    nxt_reset_n = reset_level(nxt_cfg_rst[BCC_RESET_LINK_BIT], nxt_on);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      system_reset_out_n_ff <= 1'b0;
    end else begin
      system_reset_out_n_ff <= nxt_reset_n;
    end
  end

  // ==========================================================================
  // Sequencing configuration
  // Reads zero during reset; the sequencer must not act on it before the first edge
  bcc_seq_cfg_t nxt_seq_cfg;

  always_comb begin
    nxt_seq_cfg = seq_fields(nxt_cfg_en, nxt_cfg_rst, nxt_cfg_ss);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      seq_cfg_ff <= '0;
    end else begin
      seq_cfg_ff <= nxt_seq_cfg;
    end
  end

endmodule : bcc_control

// ---- testbench/bcc_host_model.sv ----
// Host model: register accesses over the converter control request port
module bcc_host_model
  import bcc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata_ff,
  output bcc_req_t        reg_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial reg_req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    reg_req <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    reg_req <= '0;
    #1 d = reg_rdata_ff;
  endtask : rd
  // Factory and reserved bits are read back and rewritten unchanged
  task automatic rmw(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
    logic [7:0] o;
    rd(a, o);
    wr(a, (o & ~m) | (v & m));
  endtask : rmw
endmodule : bcc_host_model

// ---- testbench/bcc_control_asserts.sv ----
// Checker: relations between requests, inputs and control outputs
module bcc_control_asserts
  import bcc_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         rst,
  input wire bcc_req_t     reg_req,
  input wire bcc_pwr_t     pwr_state,
  input wire logic [7:0]   reg_rdata_ff,
  input wire logic         reg_rvalid_ff,
  input wire logic         conv_on_ff,
  input wire logic         peak_limit_select_ff,
  input wire logic         low_power_allow_ff,
  input wire logic         system_reset_out_n_ff,
  input wire bcc_seq_cfg_t seq_cfg_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic w44 = reg_req.wr_en && reg_req.addr == BCC_ENABLE_SLEEP_ADDR;
  wire logic w45 = reg_req.wr_en && reg_req.addr == BCC_RESET_DEBOUNCE_ADDR;
  wire logic w46 = reg_req.wr_en && reg_req.addr == BCC_SOFTSTART_LP_ADDR;
  wire logic [7:0] wd = reg_req.wdata;
  a_limit_write: assert property (w44 |=> peak_limit_select_ff == $past(wd[1]))
    else $error("peak limit select not updated");
  a_lp_write: assert property (w46 |=> low_power_allow_ff != $past(wd[2]))
    else $error("low power allow not updated");
  a_direct_on: assert property (w44 && wd[7] && !wd[4] && !wd[2] && pwr_state == BCC_PWR_ACTIVE
    |=> conv_on_ff) else $error("direct enable did not turn on");
  a_sleep_off: assert property (w44 && wd[4] && pwr_state == BCC_PWR_SLEEP |=> !conv_on_ff)
    else $error("converter on in sleep");
  a_deep_off: assert property (w44 && wd[2] && pwr_state == BCC_PWR_DEEP_SLEEP |=> !conv_on_ff)
    else $error("converter on in deep sleep");
  a_reset_link: assert property (w45 && wd[6] ##1 !conv_on_ff [*2] |-> !system_reset_out_n_ff)
    else $error("system reset not driven low");
  a_cfg_write: assert property (w46 |=> seq_cfg_ff.turn_on_debounce == $past(wd[7:4])
    && seq_cfg_ff.standby_input_select == $past(wd[1:0])) else $error("seq cfg stale");
  a_read_answer: assert property (reg_req.rd_en |=> reg_rvalid_ff)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid_ff |-> $past(reg_req.rd_en))
    else $error("read valid without read");
  a_reset_cfg: assert property ($fell(rst) && !reg_req.wr_en |=> seq_cfg_ff == 15'h6991)
    else $error("seq cfg reset value wrong");
endmodule : bcc_control_asserts
bind bcc_control bcc_control_asserts u_chk (.sys_clk, .rst, .reg_req, .pwr_state, .reg_rdata_ff,
  .reg_rvalid_ff, .conv_on_ff, .peak_limit_select_ff, .low_power_allow_ff,
  .system_reset_out_n_ff, .seq_cfg_ff);

// ---- testbench/bcc_control_tb.sv ----
// Testbench: scenarios for converter one configuration and control
module bcc_control_tb;
  import bcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst = 1, en = 0, inp = 0, rv, con, lim, lpa, rsn;
  bcc_pwr_t     pwr = BCC_PWR_ACTIVE;
  bcc_req_t     req;
  bcc_seq_cfg_t cfg;
  logic [7:0]   rd;
  int           n_mismatch = 0, cmp_count = 0;
  always #5 sys_clk = ~sys_clk;
  bcc_host_model host (.sys_clk(sys_clk), .reg_rdata_ff(rd), .reg_req(req));
  bcc_control uut (.sys_clk(sys_clk), .rst(rst), .reg_req(req), .seq_enable(en),
    .seq_input_on(inp), .pwr_state(pwr), .reg_rdata_ff(rd), .reg_rvalid_ff(rv),
    .conv_on_ff(con), .peak_limit_select_ff(lim), .low_power_allow_ff(lpa),
    .system_reset_out_n_ff(rsn), .seq_cfg_ff(cfg));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic setin(input logic e, input logic i, input bcc_pwr_t p);
    @(posedge sys_clk);
    en <= e;
    inp <= i;
    pwr <= p;
    @(posedge sys_clk);
    #1;
  endtask : setin
  task automatic end_of_test();
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic t_reset();
    logic [7:0] d;
    chk("seq_cfg", {1'b0, BCC_ENABLE_SLEEP_RST[6], BCC_RESET_DEBOUNCE_RST[7],
      BCC_RESET_DEBOUNCE_RST[5:0], BCC_SOFTSTART_LP_RST[7:3],
      BCC_SOFTSTART_LP_RST[1:0]}, cfg);
    host.rd(BCC_ENABLE_SLEEP_ADDR, d); chk("reg44", BCC_ENABLE_SLEEP_RST, d);
    chk("rvalid", 1, rv);
    host.rd(BCC_RESET_DEBOUNCE_ADDR, d); chk("reg45", BCC_RESET_DEBOUNCE_RST, d);
    host.rd(BCC_SOFTSTART_LP_ADDR, d); chk("reg46", BCC_SOFTSTART_LP_RST, d);
    host.rd(8'h47, d); chk("unmapped", 16'h0000, d);
  endtask : t_reset
  task automatic t_on_off();
    host.wr(8'h44, 8'hc2); chk("direct on", 1, con);
    host.wr(8'h44, 8'h42); chk("direct off", 0, con);
    setin(1, 1, BCC_PWR_ACTIVE); chk("seq on", 1, con);
    host.wr(8'h44, 8'h62); setin(1, 0, BCC_PWR_ACTIVE); chk("latched", 1, con);
    host.wr(8'h44, 8'h42); setin(1, 1, BCC_PWR_ACTIVE);
    setin(1, 0, BCC_PWR_ACTIVE); chk("unlatched", 0, con);
    setin(1, 1, BCC_PWR_SLEEP); chk("sleep stay", 1, con);
    host.wr(8'h44, 8'h52); chk("sleep off", 0, con);
    setin(1, 1, BCC_PWR_DEEP_SLEEP); chk("deep stay", 1, con);
    host.wr(8'h44, 8'h46); chk("deep off", 0, con);
    host.wr(8'h44, 8'h40); chk("limit low", 0, lim);
    host.wr(8'h44, 8'h42); chk("limit high", 1, lim);
    host.rmw(8'h46, 8'h04, 8'h04); chk("lp off", 0, lpa);
    host.rmw(8'h46, 8'h04, 8'h00); chk("lp on", 1, lpa);
  endtask : t_on_off
  task automatic t_reset_link();
    setin(0, 0, BCC_PWR_ACTIVE); chk("unlinked", 1, rsn);
    host.rmw(8'h45, 8'h40, 8'h40); chk("linked off", 0, rsn);
    setin(1, 1, BCC_PWR_ACTIVE); chk("linked on", 1, rsn);
  endtask : t_reset_link
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk);
    #1;
    t_reset();
    t_on_off();
    t_reset_link();
    end_of_test();
  end
  // Whole run is about seventy cycles; the limit leaves wide margin
  initial begin
    #100us;
    n_mismatch++;
    end_of_test();
  end
endmodule : bcc_control_tb
